// ### rtl/cit_core.sv
// Instruction decode, execution timing and result unit of the core.
`timescale 1ns/1ns

module cit_core
  import cit_pkg::*;
#(
  parameter logic [16:0] EXPANSION_DATA_RAM_BYTES = EXPANSION_DATA_RAM_ONCHIP_BYTES
) (
  input  wire logic          clk_sys,     // System clock, 250 MHz.
  input  wire logic          rstn,        // Asynchronous reset, active low.
  input  wire logic          issue_valid, // Opcode offered this cycle.
  output logic               issue_ready, // Opcode taken when both high.
  input  wire logic [7:0]    opcode,      // First byte of the instruction.
  input  wire logic [7:0]    acc_in,      // Accumulator value.
  input  wire logic [7:0]    aux_in,      // Auxiliary register value.
  input  wire logic [7:0]    src_in,      // Source operand value.
  input  wire logic [7:0]    dst_in,      // Destination byte before update.
  input  cit_flags_type      flags_in,    // Carry, half carry, overflow.
  input  wire logic [1:0]    bank_sel,    // Selected register bank.
  input  wire logic [15:0]   data_pointer_16_in,     // 16-bit data pointer.
  input  wire logic [7:0]    xpage_in,    // Upper address for 8-bit form.
  input  wire logic [7:0]    ri_in,       // Pointer register contents.
  input  wire logic          flash_sel,   // Route external move to flash.
  output logic               done,        // Last cycle of instruction.
  output cit_info_type       info,        // Decoded class and timing.
  output cit_res_type        result,      // Result byte, aux and flags.
  output logic [7:0]         reg_addr,    // Working or pointer register.
  output cit_xmove_type      xmove,       // External move routing.
  output logic [15:0]        data_pointer_16_next    // Data pointer after update.
);

  typedef struct packed {
    cit_state_type state;
    logic [3:0]    remain;
    cit_info_type  info;
    cit_res_type   res;
    logic [7:0]    reg_addr;
    cit_xmove_type xmove;
    logic [15:0]   data_pointer_16_next;
  } cit_regs_type;

  cit_regs_type s;
  cit_regs_type next_s;
  cit_info_type dec;

  // Low nibble of a regular group selects the operand form.
  function automatic cit_adr_type lo_mode(input logic [3:0] lo,
                                          input cit_adr_type at4);
    if (lo == 4'h4) begin
      return at4;
    end else if (lo == 4'h5) begin
      return ADR_DIR;
    end else if (lo < 4'h8) begin
      return ADR_IND;
    end
    return ADR_REG;
  endfunction

  function automatic cit_info_type with_form(input cit_info_type d,
                                             input cit_adr_type m);
    d.src = m;
    case (m)
      ADR_DIR, ADR_IMM: begin
        d.bytes  = LEN_TWO;
        d.cycles = CYC_TWO;
      end
      ADR_IND: begin
        d.bytes  = LEN_ONE;
        d.cycles = CYC_TWO;
      end
      default: begin
        d.bytes  = LEN_ONE;
        d.cycles = CYC_ONE;
      end
    endcase
    return d;
  endfunction

  function automatic cit_info_type decode(input logic [7:0] opc);
    cit_info_type d;
    logic [3:0]   hi;
    logic [3:0]   lo;
    hi       = opc[7:4];
    lo       = opc[3:0];
    d.op     = OP_UNSUP;
    d.src    = ADR_NONE;
    d.dst    = ADR_NONE;
    d.bytes  = LEN_ONE;
    d.cycles = CYC_ONE;
    // Standard encoding groups keep their usual opcode layout.
    if (lo >= 4'h4 && (hi == 4'h2 || hi == 4'h3 || hi == 4'h4 ||
        hi == 4'h5 || hi == 4'h6 || hi == 4'h9)) begin
      d     = with_form(d, lo_mode(lo, ADR_IMM));
      d.dst = ADR_ACC;
      case (hi)
        4'h2:    d.op = OP_ADD;
        4'h3:    d.op = OP_ADD_WITH_CARRY;
        4'h4:    d.op = OP_OR;
        4'h5:    d.op = OP_AND;
        4'h6:    d.op = OP_XOR;
        default: d.op = OP_SUBTRACT_WITH_BORROW;
      endcase
    end else if ((hi == 4'h4 || hi == 4'h5 || hi == 4'h6) &&
                 (lo == 4'h2 || lo == 4'h3)) begin
      d.op  = (hi == 4'h4) ? OP_OR : (hi == 4'h5) ? OP_AND : OP_XOR;
      d.dst = ADR_DIR;
      if (lo == 4'h2) begin
        d.src    = ADR_ACC;
        d.bytes  = LEN_TWO;
        d.cycles = CYC_TWO;
      end else begin
        d.src    = ADR_IMM;
        d.bytes  = LEN_THREE;
        d.cycles = CYC_THREE;
      end
    end else if (hi <= 4'h1 && lo >= 4'h4) begin
      d     = with_form(d, lo_mode(lo, ADR_ACC));
      d.dst = d.src;
      d.op  = (hi == 4'h0) ? OP_INC : OP_DEC;
    end else if ((hi == 4'hE && lo >= 4'h5) || opc == OPC_MOV_AIMM) begin
      d = with_form(d, (opc == OPC_MOV_AIMM) ? ADR_IMM
                                             : lo_mode(lo, ADR_IMM));
      d.dst = ADR_ACC;
      d.op  = OP_MOV;
    end else if (lo >= 4'h8 && (hi == 4'hF || hi == 4'hA || hi == 4'h7)) begin
      d = with_form(d, (hi == 4'hF) ? ADR_ACC :
                       (hi == 4'hA) ? ADR_DIR : ADR_IMM);
      d.dst = ADR_REG;
      d.op  = OP_MOV;
    end else if (opc == OPC_MOV_DA || opc == OPC_MOV_DD ||
                 (hi == 4'h8 && (lo >= 4'h8 || lo == 4'h6 || lo == 4'h7))) begin
      d.op     = OP_MOV;
      d.dst    = ADR_DIR;
      d.bytes  = LEN_TWO;
      d.cycles = CYC_TWO;
      if (opc == OPC_MOV_DA) begin
        d.src = ADR_ACC;
      end else if (opc == OPC_MOV_DD) begin
        d.src    = ADR_DIR;
        d.bytes  = LEN_THREE;
        d.cycles = CYC_THREE;
      end else begin
        d.src = (lo >= 4'h8) ? ADR_REG : ADR_IND;
      end
    end else if ((hi == 4'hE || hi == 4'hF) &&
                 (lo == 4'h0 || lo == 4'h2 || lo == 4'h3)) begin
      d.op     = OP_XMOVE;
      d.src    = hi[0] ? ADR_ACC : ADR_XDATA;
      d.dst    = hi[0] ? ADR_XDATA : ADR_ACC;
      d.cycles = CYC_XMOVE;
    end else begin
      d.dst = ADR_ACC;
      case (opc)
        OPC_NOP, OPC_NOP_ALT: begin
          d.op  = OP_NOP;
          d.dst = ADR_NONE;
        end
        OPC_INC_DATA_POINTER_16: begin
          d.op  = OP_INC_DATA_POINTER_16;
          d.dst = ADR_NONE;
        end
        OPC_MUL: begin
          d.op     = OP_MUL;
          d.cycles = CYC_MUL;
        end
        OPC_DIV: begin
          d.op     = OP_DIV;
          d.cycles = CYC_DIV;
        end
        OPC_DA:   d.op = OP_DA;
        OPC_CLR:  d.op = OP_CLR;
        OPC_CPL:  d.op = OP_CPL;
        OPC_RL:   d.op = OP_RL;
        OPC_RLC:  d.op = OP_RLC;
        OPC_RR:   d.op = OP_RR;
        OPC_RRC:  d.op = OP_RRC;
        OPC_SWAP: d.op = OP_SWAP;
        default: begin
          d.op  = OP_UNSUP;
          d.dst = ADR_NONE;
        end
      endcase
    end
    return d;
  endfunction

  function automatic cit_res_type execute(input cit_info_type  d,
                                          input logic [7:0]    acc,
                                          input logic [7:0]    aux,
                                          input logic [7:0]    src,
                                          input logic [7:0]    dst,
                                          input cit_flags_type f);
    cit_res_type r;
    logic [7:0]  a;
    logic [8:0]  t;
    logic [4:0]  n;
    logic [15:0] p;
    logic        cin;
    a       = (d.dst == ADR_ACC) ? acc : dst;
    cin     = f.cy & (d.op != OP_ADD);
    r.data  = a;
    r.aux   = aux;
    r.flags = f;
    t       = 9'h000;
    n       = 5'h00;
    p       = 16'h0000;
    case (d.op)
      OP_ADD, OP_ADD_WITH_CARRY: begin
        t = {1'b0, a} + {1'b0, src} + {8'h00, cin};
        n = {1'b0, a[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
        r.data     = t[7:0];
        r.flags.cy = t[8];
        r.flags.ac = n[4];
        r.flags.ov = (a[7] == src[7]) && (t[7] != a[7]);
      end
      OP_SUBTRACT_WITH_BORROW: begin
        // The carry enters as a borrow and leaves as the new borrow.
        t = {1'b0, a} - {1'b0, src} - {8'h00, cin};
        n = {1'b0, a[3:0]} - {1'b0, src[3:0]} - {4'h0, cin};
        r.data     = t[7:0];
        r.flags.cy = t[8];
        r.flags.ac = n[4];
        r.flags.ov = (a[7] != src[7]) && (t[7] != a[7]);
      end
      OP_INC:  r.data = a + 8'h01;
      OP_DEC:  r.data = a - 8'h01;
      OP_AND:  r.data = a & src;
      OP_OR:   r.data = a | src;
      OP_XOR:  r.data = a ^ src;
      OP_MOV:  r.data = src;
      OP_CLR:  r.data = 8'h00;
      OP_CPL:  r.data = ~a;
      OP_RL:   r.data = {a[6:0], a[7]};
      OP_RR:   r.data = {a[0], a[7:1]};
      OP_SWAP: r.data = {a[3:0], a[7:4]};
      OP_RLC: begin
        r.data     = {a[6:0], f.cy};
        r.flags.cy = a[7];
      end
      OP_RRC: begin
        r.data     = {f.cy, a[7:1]};
        r.flags.cy = a[0];
      end
      OP_DA: begin
        t = {1'b0, a};
        if (t[3:0] > DIGIT_MAX || f.ac) begin
          t = t + {1'b0, BCD_LOW_ADJ};
        end
        if (t[8] || t[7:4] > DIGIT_MAX || f.cy) begin
          t = t + {1'b0, BCD_HIGH_ADJ};
        end
        r.data     = t[7:0];
        r.flags.cy = f.cy | t[8];
      end
      OP_MUL: begin
        p = {8'h00, acc} * {8'h00, aux};
        r.data     = p[7:0];
        r.aux      = p[15:8];
        r.flags.cy = 1'b0;
        r.flags.ov = |p[15:8];
      end
      OP_DIV: begin
        // A zero divisor leaves both registers alone and raises overflow.
        r.flags.cy = 1'b0;
        r.flags.ov = (aux == 8'h00);
        if (aux != 8'h00) begin
          r.data = acc / aux;
          r.aux  = acc % aux;
        end
      end
      default: r.data = a;
    endcase
    return r;
  endfunction

  assign dec = decode(opcode);

  // Handshakes come straight from state so that a new opcode can be
  // taken in the last cycle of the current one without a bubble.
  assign done        = (s.state == ST_EXEC) && (s.remain == 4'h0);
  assign issue_ready = (s.state == ST_IDLE) || done;

  always_comb begin
    next_s = s;
    case (s.state)
      ST_IDLE: next_s.state = ST_IDLE;
      ST_EXEC: begin
        if (s.remain == 4'h0) begin
          next_s.state = ST_IDLE;
        end else begin
          next_s.remain = s.remain - 4'h1;
        end
      end
      default: next_s.state = ST_IDLE;
    endcase
    if (issue_valid && issue_ready) begin
      next_s.state  = ST_EXEC;
      next_s.info   = dec;
      // Counts never exceed the eight-cycle ceiling by construction.
      next_s.remain = (dec.cycles > CYC_LIMIT) ? (CYC_LIMIT - CYC_ONE)
                                               : (dec.cycles - CYC_ONE);
      next_s.res = execute(dec, acc_in, aux_in, src_in, dst_in, flags_in);
      if (dec.src == ADR_IND || dec.dst == ADR_IND ||
          dec.op == OP_XMOVE) begin
        next_s.reg_addr = {3'b000, bank_sel, 2'b00, opcode[0]};
      end else begin
        next_s.reg_addr = {3'b000, bank_sel, opcode[2:0]};
      end
      next_s.data_pointer_16_next = (dec.op == OP_INC_DATA_POINTER_16) ? data_pointer_16_in + 16'h0001
                                                 : data_pointer_16_in;
      next_s.xmove.write  = opcode[4];
      next_s.xmove.addr   = opcode[1] ? {xpage_in, ri_in} : data_pointer_16_in;
      if (dec.op != OP_XMOVE) begin
        next_s.xmove.target = TGT_NONE;
      end else if (flash_sel) begin
        next_s.xmove.target = TGT_FLASH;
      end else if ({1'b0, next_s.xmove.addr} < EXPANSION_DATA_RAM_BYTES) begin
        next_s.xmove.target = TGT_EXPANSION_DATA_RAM_ON;
      end else begin
        next_s.xmove.target = TGT_EXPANSION_DATA_RAM_OFF;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s       <= '0;
      s.state <= ST_IDLE;
      s.info  <= '{op: OP_NOP, src: ADR_NONE, dst: ADR_NONE,
                   bytes: LEN_ONE, cycles: CYC_ONE};
    end else begin
      s <= next_s;
    end
  end

  assign info      = s.info;
  assign result    = s.res;
  assign reg_addr  = s.reg_addr;
  assign xmove     = s.xmove;
  assign data_pointer_16_next = s.data_pointer_16_next;

endmodule

// ### rtl/cit_pkg.sv
// Shared types and constants for the instruction decode and timing block.
package cit_pkg;

  // Instruction lengths in program bytes.
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // Execution times in system clock cycles.
  localparam logic [3:0] CYC_ONE   = 4'h1;
  localparam logic [3:0] CYC_TWO   = 4'h2;
  localparam logic [3:0] CYC_THREE = 4'h3;
  localparam logic [3:0] CYC_XMOVE = 4'h3;
  localparam logic [3:0] CYC_MUL   = 4'h4;
  localparam logic [3:0] CYC_DIV   = 4'h8;
  localparam logic [3:0] CYC_LIMIT = 4'h8;

  // Size of the on-chip expansion data RAM in bytes.
  localparam logic [16:0] EXPANSION_DATA_RAM_ONCHIP_BYTES = 17'h01000;

  // Decimal adjust constants.
  localparam logic [3:0] DIGIT_MAX    = 4'h9;
  localparam logic [7:0] BCD_LOW_ADJ  = 8'h06;
  localparam logic [7:0] BCD_HIGH_ADJ = 8'h60;

  // Single opcodes that do not fall in a regular group.
  localparam logic [7:0] OPC_NOP      = 8'h00;
  localparam logic [7:0] OPC_NOP_ALT  = 8'hA5;
  localparam logic [7:0] OPC_RR       = 8'h03;
  localparam logic [7:0] OPC_RRC      = 8'h13;
  localparam logic [7:0] OPC_RL       = 8'h23;
  localparam logic [7:0] OPC_RLC      = 8'h33;
  localparam logic [7:0] OPC_MOV_AIMM = 8'h74;
  localparam logic [7:0] OPC_DIV      = 8'h84;
  localparam logic [7:0] OPC_MOV_DD   = 8'h85;
  localparam logic [7:0] OPC_INC_DATA_POINTER_16 = 8'hA3;
  localparam logic [7:0] OPC_MUL      = 8'hA4;
  localparam logic [7:0] OPC_SWAP     = 8'hC4;
  localparam logic [7:0] OPC_DA       = 8'hD4;
  localparam logic [7:0] OPC_CLR      = 8'hE4;
  localparam logic [7:0] OPC_CPL      = 8'hF4;
  localparam logic [7:0] OPC_MOV_DA   = 8'hF5;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } cit_state_type;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_INC, OP_DEC, OP_AND, OP_OR,
    OP_XOR, OP_CLR, OP_CPL, OP_RL, OP_RLC, OP_RR, OP_RRC, OP_SWAP,
    OP_DA, OP_MUL, OP_DIV, OP_MOV, OP_INC_DATA_POINTER_16, OP_XMOVE, OP_UNSUP
  } cit_op_type;

  typedef enum logic [2:0] {
    ADR_NONE, ADR_ACC, ADR_REG, ADR_DIR, ADR_IND, ADR_IMM, ADR_XDATA
  } cit_adr_type;

  typedef enum logic [1:0] {
    TGT_NONE, TGT_EXPANSION_DATA_RAM_ON, TGT_EXPANSION_DATA_RAM_OFF, TGT_FLASH
  } cit_tgt_type;

  typedef struct packed {
    logic cy;
    logic ac;
    logic ov;
  } cit_flags_type;

  typedef struct packed {
    cit_op_type  op;
    cit_adr_type src;
    cit_adr_type dst;
    logic [1:0]  bytes;
    logic [3:0]  cycles;
  } cit_info_type;

  typedef struct packed {
    logic [7:0]    data;
    logic [7:0]    aux;
    cit_flags_type flags;
  } cit_res_type;

  typedef struct packed {
    cit_tgt_type target;
    logic        write;
    logic [15:0] addr;
  } cit_xmove_type;

endpackage

// ### tb/cit_core_instr_timing_tb_top.sv
// Self-checking bench for the instruction decode and timing core.
`timescale 1ns/1ns

module cit_core_instr_timing_tb_top
  import cit_pkg::*;
;
  logic          clk_sys, rstn, issue_valid, issue_ready, flash_sel, done;
  logic [7:0]    opcode, acc_in, aux_in, src_in, dst_in, xpage_in, ri_in;
  logic [7:0]    reg_addr, mem_addr;
  logic [1:0]    bank_sel;
  logic [15:0]   data_pointer_16_in, data_pointer_16_next;
  cit_flags_type flags_in;
  cit_info_type  info;
  cit_res_type   result;
  cit_xmove_type xmove;
  int            n_errors, comparisons, n;

  cit_core u_dut (.clk_sys(clk_sys), .rstn(rstn), .issue_valid(issue_valid),
    .issue_ready(issue_ready), .opcode(opcode), .acc_in(acc_in),
    .aux_in(aux_in), .src_in(src_in), .dst_in(dst_in), .flags_in(flags_in),
    .bank_sel(bank_sel), .data_pointer_16_in(data_pointer_16_in), .xpage_in(xpage_in),
    .ri_in(ri_in), .flash_sel(flash_sel), .done(done), .info(info),
    .result(result), .reg_addr(reg_addr), .xmove(xmove),
    .data_pointer_16_next(data_pointer_16_next));
  cit_mem_model u_mem (.addr(mem_addr), .rd_data(src_in));

  task automatic chk(input string what, input logic [15:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Lowering the request one cycle after the offer leaves a bubble
  // between operations; the back-to-back case is driven separately.
  task automatic run_op(input logic [7:0] op);
    @(negedge clk_sys);
    while (issue_ready !== 1'b1) @(negedge clk_sys);
    opcode = op;
    issue_valid = 1'b1;
    @(negedge clk_sys);
    issue_valid = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 12) begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  // Each entry is opcode, byte count, cycle count.
  task automatic time_table(input logic [15:0] tab[]);
    foreach (tab[i]) begin
      run_op(tab[i][15:8]);
      chk("cycles", {12'h0, tab[i][3:0]}, n[15:0]);
      chk("info_cycles", {12'h0, tab[i][3:0]}, {12'h0, info.cycles});
      chk("info_bytes", {12'h0, tab[i][7:4]}, {14'h0, info.bytes});
    end
  endtask

  task automatic t_reset;
    chk("ready", 16'h0001, {15'h0, issue_ready});
    chk("done", 16'h0000, {15'h0, done});
  endtask

  task automatic t_arith;
    time_table('{16'h2811, 16'h2522, 16'h2612, 16'h2422, 16'h3811,
      16'h3522, 16'h3612, 16'h3422, 16'h9811, 16'h9522, 16'h9612,
      16'h9422, 16'h0411, 16'h0811, 16'h0522, 16'h0612, 16'h1411,
      16'h1811, 16'h1522, 16'h1612, 16'hA311});
  endtask

  task automatic t_logic;
    time_table('{16'h5811, 16'h5522, 16'h5612, 16'h5422, 16'h5222,
      16'h5333, 16'h4811, 16'h4522, 16'h4612, 16'h4422, 16'h4222,
      16'h4333, 16'h6811, 16'h6522, 16'h6612, 16'h6422, 16'h6222,
      16'h6333, 16'hE411, 16'hF411, 16'h2311, 16'h3311, 16'h0311,
      16'h1311, 16'hC411, 16'hD411, 16'h0011, 16'hA511,
      16'h8011});
  endtask

  task automatic t_move;
    time_table('{16'hE811, 16'hE522, 16'hE612, 16'h7422, 16'hF811,
      16'hA822, 16'h7822, 16'hF522, 16'h8822, 16'h8533,
      16'h8622});
  endtask

  task automatic t_values;
    acc_in = 8'hF0;
    mem_addr = 8'h20;
    flags_in = '{cy: 1'b1, ac: 1'b0, ov: 1'b0};
    run_op(8'h24);
    chk("add", 16'h01D3, {7'h0, result.flags.cy, result.data});
    run_op(8'h34);
    chk("add_with_carry", 16'h01D4, {7'h0, result.flags.cy, result.data});
    run_op(8'h94);
    chk("subtract_with_borrow", 16'h000C, {7'h0, result.flags.cy, result.data});
    acc_in = 8'h20;
    aux_in = 8'h10;
    run_op(OPC_MUL);
    chk("mul", 16'h0200, {result.aux, result.data});
    acc_in = 8'h64;
    aux_in = 8'h07;
    run_op(OPC_DIV);
    chk("div", 16'h020E, {result.aux, result.data});
    chk("div_cycles", 16'h0008, n[15:0]);
  endtask

  // Operands are picked so that each operation yields a distinct byte, except the pairs rl/rlc, rr/rrc
  // and cpl/swap, which give the same byte, and the destination byte differs from the accumulator.
  task automatic t_data;
    acc_in = 8'hA5;
    mem_addr = 8'h05;
    dst_in = 8'h3C;
    flags_in = '{cy: 1'b1, ac: 1'b0, ov: 1'b0};
    run_op(8'h54);
    chk("and_acc", 16'h0024, {8'h0, result.data});
    run_op(8'h44);
    chk("or_acc", 16'h00A7, {8'h0, result.data});
    run_op(8'h64);
    chk("xor_acc", 16'h0083, {8'h0, result.data});
    run_op(8'h43);
    chk("or_dir", 16'h003E, {8'h0, result.data});
    chk("or_dir_form", {10'h0, ADR_IMM, ADR_DIR},
        {10'h0, info.src, info.dst});
    run_op(8'h05);
    chk("inc_dir", 16'h003D, {8'h0, result.data});
    run_op(8'h16);
    chk("dec_ind", 16'h003B, {8'h0, result.data});
    run_op(8'hE5);
    chk("mov_acc", 16'h0026, {8'h0, result.data});
    run_op(OPC_RLC);
    chk("rlc", 16'h014B, {7'h0, result.flags.cy, result.data});
    run_op(OPC_RRC);
    chk("rrc", 16'h01D2, {7'h0, result.flags.cy, result.data});
    run_op(OPC_RL);
    chk("rl", 16'h004B, {8'h0, result.data});
    run_op(OPC_RR);
    chk("rr", 16'h00D2, {8'h0, result.data});
    run_op(OPC_CPL);
    chk("cpl", 16'h005A, {8'h0, result.data});
    run_op(OPC_SWAP);
    chk("swap", 16'h005A, {8'h0, result.data});
    run_op(OPC_CLR);
    chk("clr", 16'h0000, {8'h0, result.data});
    acc_in = 8'h9B;
    flags_in = '0;
    run_op(OPC_DA);
    chk("da", 16'h0101, {7'h0, result.flags.cy, result.data});
    acc_in = 8'h55;
    aux_in = 8'h00;
    run_op(OPC_DIV);
    chk("div0", 16'h0055, {result.aux, result.data});
    chk("div0_flags", 16'h0001,
        {14'h0, result.flags.cy, result.flags.ov});
    run_op(8'h80);
    chk("unsup_op", {11'h0, OP_UNSUP}, {11'h0, info.op});
  endtask

  // A reset in the middle of a long operation must drop it at once.
  task automatic t_mid_reset;
    @(negedge clk_sys);
    while (issue_ready !== 1'b1) @(negedge clk_sys);
    opcode = OPC_DIV;
    issue_valid = 1'b1;
    @(negedge clk_sys);
    issue_valid = 1'b0;
    @(negedge clk_sys);
    rstn = 1'b0;
    @(negedge clk_sys);
    chk("rst_ready", 16'h0001, {15'h0, issue_ready});
    chk("rst_done", 16'h0000, {15'h0, done});
    chk("rst_op", {11'h0, OP_NOP}, {11'h0, info.op});
    rstn = 1'b1;
    run_op(8'h28);
    chk("rst_cycles", 16'h0001, n[15:0]);
  endtask

  task automatic xm(input logic [7:0] op, input logic [2:0] tw,
                    input logic [15:0] adr);
    run_op(op);
    chk("xmove_route", {13'h0, tw}, {13'h0, xmove.target, xmove.write});
    chk("xmove_addr", adr, xmove.addr);
    chk("xmove_cycles", 16'h0003, n[15:0]);
  endtask

  task automatic t_xmove;
    data_pointer_16_in = 16'h0800;
    xm(8'hE0, {TGT_EXPANSION_DATA_RAM_ON, 1'b0}, 16'h0800);
    data_pointer_16_in = 16'h2000;
    xm(8'hF0, {TGT_EXPANSION_DATA_RAM_OFF, 1'b1}, 16'h2000);
    flash_sel = 1'b1;
    xm(8'hF0, {TGT_FLASH, 1'b1}, 16'h2000);
    flash_sel = 1'b0;
    xpage_in = 8'h12;
    ri_in = 8'h34;
    xm(8'hF2, {TGT_EXPANSION_DATA_RAM_OFF, 1'b1}, 16'h1234);
  endtask

  task automatic t_regs;
    bank_sel = 2'h2;
    run_op(8'h27);
    chk("ind_reg", 16'h0011, {8'h0, reg_addr});
    bank_sel = 2'h1;
    run_op(8'h2B);
    chk("work_reg", 16'h000B, {8'h0, reg_addr});
    data_pointer_16_in = 16'hFFFF;
    run_op(OPC_INC_DATA_POINTER_16);
    chk("data_pointer_16_wrap", 16'h0000, data_pointer_16_next);
  endtask

  task automatic t_back_to_back;
    acc_in = 8'h20;
    @(negedge clk_sys);
    opcode = OPC_MUL;
    issue_valid = 1'b1;
    @(negedge clk_sys);
    opcode = 8'h04;
    n = 1;
    while (done !== 1'b1 && n < 12) begin
      @(negedge clk_sys);
      n++;
    end
    chk("b2b_mul", 16'h0004, n[15:0]);
    @(negedge clk_sys);
    issue_valid = 1'b0;
    chk("b2b_done", 16'h0001, {15'h0, done});
    chk("b2b_op", {11'h0, OP_INC}, {11'h0, info.op});
    chk("b2b_data", 16'h0021, {8'h0, result.data});
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    stop_test();
  end

  initial begin
    {rstn, issue_valid, flash_sel, bank_sel} = '0;
    {opcode, acc_in, aux_in, dst_in, xpage_in, ri_in, mem_addr} = '0;
    data_pointer_16_in = 16'h0000;
    flags_in = '0;
    repeat (20) @(negedge clk_sys);
    t_reset();
    rstn = 1'b1;
    t_arith();
    t_logic();
    t_move();
    t_values();
    t_data();
    t_mid_reset();
    t_xmove();
    t_regs();
    t_back_to_back();
    stop_test();
  end
endmodule

// ### tb/cit_core_props.sv
// Concurrent checks on the decode and timing ports of the core.
`timescale 1ns/1ns

module cit_core_props
  import cit_pkg::*;
(
  input wire logic          clk_sys,     // System clock.
  input wire logic          rstn,        // Reset, active low.
  input wire logic          issue_valid, // Opcode offered.
  input wire logic          issue_ready, // Core can take an opcode.
  input wire logic [7:0]    opcode,      // First instruction byte.
  input wire logic [1:0]    bank_sel,    // Selected bank.
  input wire logic [15:0]   data_pointer_16_in,     // Data pointer in.
  input wire logic          flash_sel,   // Flash routing.
  input wire logic          done,        // Last cycle.
  input cit_info_type       info,        // Decoded timing.
  input wire logic [7:0]    reg_addr,    // Register address.
  input cit_xmove_type      xmove,       // External move routing.
  input wire logic [15:0]   data_pointer_16_next    // Data pointer out.
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  logic       take;
  logic       is_xmove;
  logic [3:0] busy_cnt;
  logic [3:0] next_busy_cnt;

  assign take = issue_valid && issue_ready;
  assign is_xmove = opcode[7:5] == 3'h7 && opcode[3:2] == 2'h0
                    && opcode[1:0] != 2'h1;

  // Counts busy cycles so the longest instruction can be bounded cheaply.
  always_comb begin
    next_busy_cnt = issue_ready ? 4'h0 : busy_cnt + 4'h1;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy_cnt <= 4'h0;
    end else begin
      busy_cnt <= next_busy_cnt;
    end
  end

  sequence s_mul_wait;
    (!done && !issue_ready) [*3] ##1 (done && issue_ready);
  endsequence

  sequence s_div_wait;
    !done [*7] ##1 done;
  endsequence

  a_mul_four_cycles: assert property (
    take && opcode == OPC_MUL |=> s_mul_wait)
    else $error("multiply did not finish in four cycles");
  a_div_eight_cycles: assert property (
    take && opcode == OPC_DIV |=> s_div_wait)
    else $error("divide did not finish in eight cycles");
  a_bound_eight: assert property (busy_cnt <= 4'h7)
    else $error("instruction ran past eight cycles");
  a_single_done: assert property (
    take |=> done == (info.cycles == CYC_ONE))
    else $error("done timing disagrees with cycle count");
  a_and_imm_direct: assert property (
    take && opcode == 8'h53 |=> info.bytes == LEN_THREE
    && info.cycles == CYC_THREE && !done ##2 done)
    else $error("and immediate into direct not three bytes three cycles");
  a_data_pointer_16_step: assert property (
    take && opcode == OPC_INC_DATA_POINTER_16 |=> done
    && data_pointer_16_next == $past(data_pointer_16_in) + 16'h0001)
    else $error("data pointer increment wrong");
  a_ptr_reg_bank: assert property (
    take && opcode[3:1] == 3'h3 && opcode[7:4] inside {4'h2, 4'h9}
    |=> reg_addr == {3'h0, $past(bank_sel), 2'h0, $past(opcode[0])})
    else $error("pointer register address wrong");
  a_xmove_route: assert property (
    take && is_xmove |=> xmove.write == $past(opcode[4])
    && (!$past(flash_sel) || xmove.target == TGT_FLASH) ##2 done)
    else $error("external move routing or timing wrong");
endmodule

bind cit_core cit_core_props u_props (
  .clk_sys(clk_sys), .rstn(rstn), .issue_valid(issue_valid),
  .issue_ready(issue_ready), .opcode(opcode), .bank_sel(bank_sel),
  .data_pointer_16_in(data_pointer_16_in), .flash_sel(flash_sel), .done(done), .info(info),
  .reg_addr(reg_addr), .xmove(xmove), .data_pointer_16_next(data_pointer_16_next));

// ### tb/cit_mem_model.sv
// Behavioural data memory that answers operand reads for the core.
`timescale 1ns/1ns

module cit_mem_model (
  input  wire logic [7:0] addr,    // Byte address of the operand.
  output logic      [7:0] rd_data  // Byte returned to the core.
);
  logic [7:0] mem [256];

  // A fixed fill keeps every operand computable by the bench.
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i * 7 + 3);
    end
  end

  assign rd_data = mem[addr];
endmodule
